// ---- bench/cpe_cache_parity_ctl_tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cpe_cache_parity_ctl_tb;
  import cpe_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic cp0_wr_en = 0;
  logic cp0_wr_sel = 0;
  logic [31:0] cp0_wr_data = '0;
  logic cp0_rd_sel = 0;
  logic [31:0] cp0_rd_data, rd_data_np, rv, rv2;
  logic bus_err_valid = 0;
  logic bus_err_load = 0;
  logic bus_err_store_lost = 0;
  logic handler_start = 0;
  cpe_cacheop_s cacheop = '0;
  cpe_fault_s fault = '0;
  cpe_store_s store_out, so;
  cpe_array_e array_mode;
  logic l1_parity_on, l2_ecc_on, itag_ws_map;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  cpe_cache_parity_ctl #(.PARITY_IMPL(1'b1)) u_cpe_cache_parity_ctl (.clk(clk), .rst(rst),
    .cp0_wr_en(cp0_wr_en), .cp0_wr_sel(cp0_wr_sel), .cp0_wr_data(cp0_wr_data),
    .cp0_rd_sel(cp0_rd_sel), .cp0_rd_data(cp0_rd_data), .bus_err_valid(bus_err_valid),
    .bus_err_load(bus_err_load), .bus_err_store_lost(bus_err_store_lost),
    .cacheop(cacheop), .store_out(store_out), .fault(fault), .handler_start(handler_start),
    .array_mode(array_mode), .l1_parity_on(l1_parity_on), .l2_ecc_on(l2_ecc_on),
    .itag_ws_map(itag_ws_map));
  // Build without the parity option, watched only through its read port
  cpe_cache_parity_ctl #(.PARITY_IMPL(1'b0)) u_cpe_cache_parity_ctl_nopar (.clk(clk),
    .rst(rst), .cp0_wr_en(cp0_wr_en), .cp0_wr_sel(cp0_wr_sel), .cp0_wr_data(cp0_wr_data),
    .cp0_rd_sel(cp0_rd_sel), .cp0_rd_data(rd_data_np), .bus_err_valid(bus_err_valid),
    .bus_err_load(bus_err_load), .bus_err_store_lost(bus_err_store_lost),
    .cacheop(cacheop), .store_out(), .fault(fault), .handler_start(handler_start),
    .array_mode(), .l1_parity_on(), .l2_ecc_on(), .itag_ws_map());

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Guards against a hang; the whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic sel, input logic [31:0] d);
    cp0_wr_en = 1;
    cp0_wr_sel = sel;
    cp0_wr_data = d;
    tick();
    cp0_wr_en = 0;
  endtask

  task automatic rd(input logic sel);
    cp0_rd_sel = sel;
    tick();
    tick();
    rv = cp0_rd_data;
    rv2 = rd_data_np;
  endtask

  // Extra cycles let the registered parity level settle before an operation
  task automatic wrs(input logic [31:0] d);
    wr(0, d);
    tick();
    tick();
  endtask

  task automatic op(input cpe_op_e o, input logic ic);
    cacheop.valid = 1;
    cacheop.op = o;
    cacheop.icache = ic;
    tick();
    cacheop.valid = 0;
    so = store_out;
    tick();
  endtask

  task automatic flt(input cpe_fault_s f, input logic [31:0] e);
    f.valid = 1;
    fault = f;
    tick();
    fault.valid = 0;
    rd(1);
    `CHK("capture", e, rv)
  endtask

  task automatic t_reset();
    rd(0);
    `CHK("ctl reset", 32'h0, rv)
    rd(1);
    `CHK("cap reset", 32'h0, rv)
    `CHK("mode reset", ARR_NORMAL, array_mode)
    wr(0, 32'hffff_ffff);
    rd(0);
    `CHK("ctl all ones", 32'hfc87_ffff, rv)
    `CHK("ctl no parity", 32'h7c87_ffff, rv2)
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [31:0] d;
    logic [2:0] m;
    cpe_array_e e;
    for (int i = 0; i < 32; i++) begin
      m = i[2:0];
      d = {i[4], 1'b0, m[2], m[1], 1'b0, m[0], 2'b00, i[3], 23'h0};
      wr(0, d);
      rd(0);
      case (m)
        3'b000: e = ARR_NORMAL;
        3'b010: e = ARR_SCRATCH;
        3'b100: e = ARR_WAYSEL;
        3'b110: e = ARR_DUPTAG;
        3'b001: e = ARR_THREAD;
        default: e = ARR_RESERVED;
      endcase
      `CHK("ctl mode", d, rv)
      `CHK("array mode", e, array_mode)
      `CHK("l1 parity", i[4], l1_parity_on)
      `CHK("l2 ecc", i[4] ^ i[3], l2_ecc_on)
      `CHK("way map", m[2], itag_ws_map)
    end
    $display("test modes done");
  endtask

  task automatic t_bus();
    for (int i = 1; i < 4; i++) begin
      bus_err_load = i[1];
      bus_err_store_lost = i[0];
      bus_err_valid = 1;
      tick();
      bus_err_valid = 0;
      rd(0);
      `CHK("bus flags", i[1:0], rv[25:24])
    end
    $display("test bus done");
  endtask

  task automatic t_store();
    cacheop.tag_parity_calc = 1;
    cacheop.tag_lo_parity = 0;
    cacheop.dparity_calc = 4'h5;
    cacheop.iparity_calc = 9'h055;
    cacheop.precode_calc = 6'h15;
    wrs(32'h8005_5aaa);
    op(OP_STORE_TAG, 0);
    `CHK("st valid", 1'b1, so.valid)
    `CHK("st op", OP_STORE_TAG, so.op)
    `CHK("st array", ARR_NORMAL, so.array)
    `CHK("tag par calc", 1'b1, so.tag_parity)
    `CHK("d par calc", 4'h5, so.dparity)
    op(OP_STORE_DATA, 1);
    `CHK("i par calc", 9'h055, so.iparity)
    `CHK("precode calc", 6'h15, so.precode)
    wrs(32'hc805_5aaa);
    op(OP_STORE_TAG, 0);
    `CHK("tag par ovr", 1'b0, so.tag_parity)
    `CHK("d par ovr", 4'ha, so.dparity)
    op(OP_STORE_DATA, 1);
    `CHK("i par ovr", 9'h1aa, so.iparity)
    `CHK("precode ovr", 6'h2a, so.precode)
    wrs(32'h0805_5aaa);
    op(OP_STORE_DATA, 1);
    `CHK("i par off", 9'h000, so.iparity)
    `CHK("precode ovr off", 6'h2a, so.precode)
    $display("test store done");
  endtask

  task automatic t_load();
    cacheop.rd_precode = 6'h33;
    cacheop.rd_iparity = 9'h0f0;
    cacheop.rd_dparity = 4'h9;
    wrs(32'h8000_0000);
    op(OP_LOAD_TAG, 1);
    rd(0);
    `CHK("ld precode", 6'h33, rv[18:13])
    `CHK("ld i par", 9'h0f0, rv[12:4])
    `CHK("ld i par absent", 9'h000, rv2[12:4])
    op(OP_LOAD_TAG, 0);
    rd(0);
    `CHK("ld d par", 4'h9, rv[3:0])
    `CHK("ld d par absent", 4'h0, rv2[3:0])
    wrs(32'h0000_0000);
    op(OP_LOAD_TAG, 1);
    op(OP_LOAD_TAG, 0);
    rd(0);
    `CHK("ld i par off", 9'h000, rv[12:4])
    `CHK("ld d par off", 4'h0, rv[3:0])
    $display("test load done");
  endtask

  task automatic hstart();
    handler_start = 1;
    tick();
    handler_start = 0;
  endtask

  task automatic t_fault();
    cpe_fault_s f;
    f = '0;
    f.is_data = 1;
    f.tag_err = 1;
    f.data_err = 1;
    f.index = 20'h12345;
    flt(f, 32'h9201_2345);
    f = '0;
    f.is_data = 1;
    f.data_err = 1;
    flt(f, 32'ha100_0000);
    hstart();
    f = '0;
    f.data_err = 1;
    f.from_snoop = 1;
    f.remote_cpu = 1;
    f.scratch_err = 1;
    f.index = 20'h00abc;
    flt(f, 32'h2c80_0abc);
    hstart();
    f = '0;
    f.is_data = 1;
    f.dup_tag_err = 1;
    f.way_err = 1;
    f.details_lost = 1;
    flt(f, 32'hb300_0000);
    hstart();
    f = '0;
    f.tag_err = 1;
    f.data_err = 1;
    f.way_err = 1;
    flt(f, 32'h1200_0000);
    hstart();
    f = '0;
    f.non_primary = 1;
    f.way_err = 1;
    flt(f, 32'h4040_0000);
    wr(1, 32'hffff_ffff);
    rd(1);
    `CHK("cap read only", 32'h4040_0000, rv)
    $display("test fault done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 0;
    t_reset();
    t_modes();
    t_bus();
    t_store();
    t_load();
    t_fault();
    test_done();
  end
endmodule

// ---- logic/cpe_cache_parity_ctl.sv ----
`timescale 1ns/1ns
module cpe_cache_parity_ctl #(
  parameter bit PARITY_IMPL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Coprocessor register moves
  input wire logic cp0_wr_en,
  input wire logic cp0_wr_sel,
  input wire logic [31:0] cp0_wr_data,
  input wire logic cp0_rd_sel,
  output logic [31:0] cp0_rd_data,
  // Data bus error report
  input wire logic bus_err_valid,
  input wire logic bus_err_load,
  input wire logic bus_err_store_lost,
  // Index cache operations
  input wire cpe_pkg::cpe_cacheop_s cacheop,
  output cpe_pkg::cpe_store_s store_out,
  // Cache error exception
  input wire cpe_pkg::cpe_fault_s fault,
  input wire logic handler_start,
  // Mode outputs
  output cpe_pkg::cpe_array_e array_mode,
  output logic l1_parity_on,
  output logic l2_ecc_on,
  output logic itag_ws_map
);
  import cpe_pkg::*;

  typedef struct packed {
    cpe_ctl_s ctl;
    logic [31:0] rd_data;
    cpe_array_e mode;
    logic l1_on;
    logic l2_on;
    logic ws_map;
  } cpe_state_s;

  cpe_state_s s_reg;
  cpe_state_s s_next;
  logic parity_on;
  logic [31:0] cap_word;
  logic ld_tag;

  assign parity_on = PARITY_IMPL && s_reg.ctl.parity_enable;
  assign ld_tag = cacheop.valid && cacheop.op == OP_LOAD_TAG;

  always_comb begin
    s_next = s_reg;
    if (cp0_wr_en && cp0_wr_sel == SEL_CONTROL) begin
      // Bits 25:24 and 22:19 are not writable
      s_next.ctl.parity_enable = PARITY_IMPL && cp0_wr_data[PE_BIT];
      s_next.ctl.parity_override = cp0_wr_data[PO_BIT];
      s_next.ctl.way_select_test = cp0_wr_data[WST_BIT];
      s_next.ctl.scratchpad_tag_test = cp0_wr_data[SPR_BIT];
      s_next.ctl.precode_override = cp0_wr_data[PCO_BIT];
      s_next.ctl.thread_comm_tag_test = cp0_wr_data[ITC_BIT];
      s_next.ctl.l2_check_invert = cp0_wr_data[L2P_BIT];
      s_next.ctl.precode = cp0_wr_data[PCI_LSB +: PCI_W];
      s_next.ctl.icache_data_parity = cp0_wr_data[PI_LSB +: PI_W];
      s_next.ctl.dcache_word_parity = cp0_wr_data[PD_LSB +: PD_W];
    end
    // Hardware updates follow the software write so they win a same-cycle clash
    if (bus_err_valid) begin
      s_next.ctl.load_bus_fault = bus_err_load;
      s_next.ctl.write_alloc_bus_fault = bus_err_store_lost;
    end
    if (ld_tag) begin
      if (cacheop.icache) begin
        s_next.ctl.precode = cacheop.rd_precode;
        s_next.ctl.icache_data_parity = parity_on ? cacheop.rd_iparity : '0;
      end else begin
        s_next.ctl.dcache_word_parity = parity_on ? cacheop.rd_dparity : '0;
      end
    end
    // Reads return the value as of the previous edge
    s_next.rd_data = (cp0_rd_sel == SEL_CAPTURE) ? cap_word : cpe_pack_ctl(s_reg.ctl);
    s_next.mode = cpe_decode_mode(cpe_mode_bits(s_reg.ctl));
    s_next.l1_on = parity_on;
    s_next.l2_on = s_reg.ctl.parity_enable ^ s_reg.ctl.l2_check_invert;
    s_next.ws_map = s_reg.ctl.way_select_test;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctl <= cpe_ctl_s'(CTL_RESET[$bits(cpe_ctl_s)-1:0]);
      s_reg.mode <= ARR_NORMAL;
    end else begin
      s_reg <= s_next;
    end
  end

  cpe_store_sel u_store_sel (
    .clk(clk),
    .rst(rst),
    .ctl(s_reg.ctl),
    .parity_on(parity_on),
    .cacheop(cacheop),
    .store_out(store_out)
  );

  cpe_err_capture u_err_capture (
    .clk(clk),
    .rst(rst),
    .fault(fault),
    .handler_start(handler_start),
    .cap_word(cap_word)
  );

  assign cp0_rd_data = s_reg.rd_data;
  assign array_mode = s_reg.mode;
  assign l1_parity_on = s_reg.l1_on;
  assign l2_ecc_on = s_reg.l2_on;
  assign itag_ws_map = s_reg.ws_map;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ctl_write;
    cp0_wr_en && cp0_wr_sel == SEL_CONTROL;
  endsequence

  sequence s_ctl_read;
    cp0_rd_sel == SEL_CONTROL;
  endsequence

  a_pe_write: assert property (s_ctl_write
    |=> s_reg.ctl.parity_enable == (PARITY_IMPL && $past(cp0_wr_data[PE_BIT])))
    else $error("parity enable not written");
  a_pe_absent: assert property ((!PARITY_IMPL and s_ctl_read) |=> !cp0_rd_data[PE_BIT])
    else $error("parity enable readable without option");
  a_l2_ecc: assert property (s_ctl_write ##1 !cp0_wr_en
    |=> l2_ecc_on == (($past(cp0_wr_data[PE_BIT], 2) && PARITY_IMPL)
                      ^ $past(cp0_wr_data[L2P_BIT], 2)))
    else $error("l2 check state wrong");
  a_rsvd_zero: assert property (s_ctl_read |=> cp0_rd_data[22:19] == 4'h0)
    else $error("reserved control bits not zero");
  a_bus_fault: assert property (bus_err_valid
    |=> s_reg.ctl.load_bus_fault == $past(bus_err_load)
        && s_reg.ctl.write_alloc_bus_fault == $past(bus_err_store_lost))
    else $error("bus fault flags not updated");
  a_itag_load: assert property (ld_tag && cacheop.icache
    |=> s_reg.ctl.precode == $past(cacheop.rd_precode))
    else $error("precode not captured");
  a_parity_zero: assert property (ld_tag && !parity_on
    |=> s_reg.ctl.icache_data_parity == '0 || !$past(cacheop.icache))
    else $error("parity readback not zero");
  a_dtag_load: assert property (ld_tag && !cacheop.icache && parity_on
    |=> s_reg.ctl.dcache_word_parity == $past(cacheop.rd_dparity))
    else $error("data parity not captured");
  a_mode_decode: assert property (s_ctl_write ##1 !cp0_wr_en
    |=> array_mode == cpe_decode_mode({$past(cp0_wr_data[WST_BIT], 2),
        $past(cp0_wr_data[SPR_BIT], 2), $past(cp0_wr_data[ITC_BIT], 2)}))
    else $error("test mode decode wrong");
  a_ws_map: assert property (s_ctl_write ##1 !cp0_wr_en
    |=> itag_ws_map == $past(cp0_wr_data[WST_BIT], 2))
    else $error("way select map wrong");
endmodule

// ---- logic/cpe_err_capture.sv ----
`timescale 1ns/1ns
module cpe_err_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fault report and handler progress
  input wire cpe_pkg::cpe_fault_s fault,
  input wire logic handler_start,
  // Captured word
  output logic [31:0] cap_word
);
  import cpe_pkg::*;

  typedef struct packed {
    logic [31:0] cap;
    logic pending;
  } cpe_cap_s;

  cpe_cap_s s_reg;
  cpe_cap_s s_next;
  logic tag_any;
  logic [2:0] n_err;

  always_comb begin
    s_next = s_reg;
    tag_any = fault.tag_err || fault.dup_tag_err;
    n_err = 3'(fault.tag_err) + 3'(fault.dup_tag_err) + 3'(fault.data_err)
          + 3'(fault.way_err);
    if (handler_start) begin
      s_next.pending = 1'b0;
    end
    if (fault.valid) begin
      s_next.cap = '0;
      s_next.cap[ER_BIT] = fault.is_data;
      s_next.cap[EC_BIT] = fault.non_primary;
      if (fault.is_data) begin
        if (fault.tag_err) begin
          s_next.cap[ED_BIT:ET_BIT] = 2'h1;
        end else if (fault.dup_tag_err) begin
          s_next.cap[ED_BIT:ET_BIT] = 2'h3;
        end else if (fault.data_err) begin
          s_next.cap[ED_BIT:ET_BIT] = 2'h2;
        end
      end else begin
        s_next.cap[ET_BIT] = tag_any;
        s_next.cap[ED_BIT] = fault.data_err && !tag_any;
      end
      s_next.cap[EW_BIT] = fault.way_err && !tag_any && !fault.data_err;
      s_next.cap[ES_BIT] = fault.from_snoop;
      s_next.cap[EE_BIT] = fault.remote_cpu;
      s_next.cap[EB_BIT] = n_err > 3'h1;
      // A second error before the handler runs overwrites unseen details
      s_next.cap[EF_BIT] = fault.details_lost || s_reg.pending;
      s_next.cap[SP_BIT] = fault.scratch_err;
      s_next.cap[WAY_LSB +: WAY_W] = fault.way;
      s_next.cap[IDX_W-1:0] = fault.index;
      s_next.pending = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= {CAP_RESET, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cap_word = s_reg.cap;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_fault_pending;
    fault.valid ##1 (!handler_start)[*3] ##0 fault.valid;
  endsequence

  a_cap_fatal: assert property (s_fault_pending |=> cap_word[EF_BIT])
    else $error("fatal flag missing on overlapping faults");
  a_cap_priority: assert property (fault.valid && !fault.is_data && fault.tag_err
    |=> cap_word[ET_BIT] && !cap_word[ED_BIT] && !cap_word[EW_BIT])
    else $error("tag fault not given priority");
  a_cap_extra: assert property (fault.valid && fault.data_err && fault.way_err
    |=> cap_word[EB_BIT])
    else $error("additional fault flag missing");
  a_cap_kind: assert property (fault.valid
    |=> cap_word[ER_BIT] == $past(fault.is_data) && cap_word[SP_BIT] == $past(fault.scratch_err))
    else $error("access kind or scratchpad flag wrong");
endmodule

// ---- logic/cpe_pkg.sv ----
package cpe_pkg;
  // Control register bit positions
  localparam int PE_BIT = 31;
  localparam int PO_BIT = 30;
  localparam int WST_BIT = 29;
  localparam int SPR_BIT = 28;
  localparam int PCO_BIT = 27;
  localparam int ITC_BIT = 26;
  localparam int LBE_BIT = 25;
  localparam int WRITE_ALLOC_BUS_FAULT_BIT = 24;
  localparam int L2P_BIT = 23;
  localparam int PCI_LSB = 13;
  localparam int PCI_W = 6;
  localparam int PI_LSB = 4;
  localparam int PI_W = 9;
  localparam int PD_LSB = 0;
  localparam int PD_W = 4;
  // Capture register bit positions
  localparam int ER_BIT = 31;
  localparam int EC_BIT = 30;
  localparam int ED_BIT = 29;
  localparam int ET_BIT = 28;
  localparam int ES_BIT = 27;
  localparam int EE_BIT = 26;
  localparam int EB_BIT = 25;
  localparam int EF_BIT = 24;
  localparam int SP_BIT = 23;
  localparam int EW_BIT = 22;
  localparam int WAY_LSB = 20;
  localparam int WAY_W = 2;
  localparam int IDX_W = 20;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CAP_RESET = 32'h0000_0000;
  // Register selects of the coprocessor move
  localparam logic SEL_CONTROL = 1'h0;
  localparam logic SEL_CAPTURE = 1'h1;
  // Test mode codes, ordered {way select, scratchpad, thread comm}
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SCRATCH = 3'h2;
  localparam logic [2:0] MODE_WAYSEL = 3'h4;
  localparam logic [2:0] MODE_DUPTAG = 3'h6;
  localparam logic [2:0] MODE_THREAD = 3'h1;

  typedef enum logic [2:0] {
    ARR_NORMAL, ARR_SCRATCH, ARR_WAYSEL, ARR_DUPTAG, ARR_THREAD, ARR_RESERVED
  } cpe_array_e;

  typedef enum logic [1:0] {OP_NONE, OP_LOAD_TAG, OP_STORE_TAG, OP_STORE_DATA} cpe_op_e;

  typedef struct packed {
    logic parity_enable;
    logic parity_override;
    logic way_select_test;
    logic scratchpad_tag_test;
    logic precode_override;
    logic thread_comm_tag_test;
    logic load_bus_fault;
    logic write_alloc_bus_fault;
    logic l2_check_invert;
    logic [PCI_W-1:0] precode;
    logic [PI_W-1:0] icache_data_parity;
    logic [PD_W-1:0] dcache_word_parity;
  } cpe_ctl_s;

  typedef struct packed {
    logic valid;
    cpe_op_e op;
    logic icache;
    logic tag_parity_calc;
    logic tag_lo_parity;
    logic [PCI_W-1:0] precode_calc;
    logic [PI_W-1:0] iparity_calc;
    logic [PD_W-1:0] dparity_calc;
    logic [PCI_W-1:0] rd_precode;
    logic [PI_W-1:0] rd_iparity;
    logic [PD_W-1:0] rd_dparity;
  } cpe_cacheop_s;

  typedef struct packed {
    logic valid;
    logic is_data;
    logic non_primary;
    logic from_snoop;
    logic remote_cpu;
    logic tag_err;
    logic dup_tag_err;
    logic data_err;
    logic way_err;
    logic scratch_err;
    logic details_lost;
    logic [WAY_W-1:0] way;
    logic [IDX_W-1:0] index;
  } cpe_fault_s;

  typedef struct packed {
    logic valid;
    cpe_op_e op;
    logic icache;
    cpe_array_e array;
    logic tag_parity;
    logic [PI_W-1:0] iparity;
    logic [PD_W-1:0] dparity;
    logic [PCI_W-1:0] precode;
  } cpe_store_s;

  function automatic cpe_array_e cpe_decode_mode(input logic [2:0] m);
    cpe_array_e a;
    unique case (m)
      MODE_NORMAL: a = ARR_NORMAL;
      MODE_SCRATCH: a = ARR_SCRATCH;
      MODE_WAYSEL: a = ARR_WAYSEL;
      MODE_DUPTAG: a = ARR_DUPTAG;
      MODE_THREAD: a = ARR_THREAD;
      default: a = ARR_RESERVED;
    endcase
    return a;
  endfunction

  function automatic logic [2:0] cpe_mode_bits(input cpe_ctl_s c);
    return {c.way_select_test, c.scratchpad_tag_test, c.thread_comm_tag_test};
  endfunction

  // Bits 22:19 always read as zero
  function automatic logic [31:0] cpe_pack_ctl(input cpe_ctl_s c);
    return {c.parity_enable, c.parity_override, c.way_select_test, c.scratchpad_tag_test,
      c.precode_override, c.thread_comm_tag_test, c.load_bus_fault,
      c.write_alloc_bus_fault, c.l2_check_invert, 4'h0, c.precode,
      c.icache_data_parity, c.dcache_word_parity};
  endfunction
endpackage

// ---- logic/cpe_store_sel.sv ----
`timescale 1ns/1ns
module cpe_store_sel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control state and cache operation
  input wire cpe_pkg::cpe_ctl_s ctl,
  input wire logic parity_on,
  input wire cpe_pkg::cpe_cacheop_s cacheop,
  // Values sent to the arrays
  output cpe_pkg::cpe_store_s store_out
);
  import cpe_pkg::*;

  cpe_store_s s_reg;
  cpe_store_s s_next;

  always_comb begin
    s_next = '0;
    s_next.valid = cacheop.valid && cacheop.op != OP_NONE;
    s_next.op = cacheop.op;
    s_next.icache = cacheop.icache;
    s_next.array = cpe_decode_mode(cpe_mode_bits(ctl));
    // Parity fields stay zero with protection off so arrays see a clean value
    if (parity_on) begin
      s_next.tag_parity = ctl.parity_override ? cacheop.tag_lo_parity
                                              : cacheop.tag_parity_calc;
      s_next.iparity = ctl.parity_override ? ctl.icache_data_parity
                                           : cacheop.iparity_calc;
      s_next.dparity = ctl.parity_override ? ctl.dcache_word_parity
                                           : cacheop.dparity_calc;
    end
    s_next.precode = ctl.precode_override ? ctl.precode : cacheop.precode_calc;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign store_out = s_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_po_tag_source: assert property (cacheop.valid && parity_on && ctl.parity_override
    |=> store_out.tag_parity == $past(cacheop.tag_lo_parity))
    else $error("tag parity not taken from staging register");
  a_pco_precode: assert property (cacheop.valid && !ctl.precode_override
    |=> store_out.precode == $past(cacheop.precode_calc))
    else $error("generated precode not used");
endmodule
